// [design/ria_alias_remap.v]
`timescale 1ns/10ps
`include "ria_defines.vh"

// How it works
// - one register copy per receive port; port select picks the copy
// - physical target address in bits 7:1, reset zero, bit 0 reads zero
// - matching alias slot's physical address replaces the host address
// - alias address in bits 7:1, read-write, reset zero, feeds the decoder
// - an alias of zero never matches, disabling that target
// - alias bit 0 auto-acknowledges writes regardless of link or remote ack
module ria_alias_remap
#(
    parameter NPORT = 4,
    parameter PW    = 2
)
(
    input  wire                                     core_clk,
    input  wire                                     rst_n,
    input  wire [PW-1:0]                            port_sel,
    input  wire                                     reg_wr,
    input  wire                                     reg_rd,
    input  wire [7:0]                               reg_addr,
    input  wire [`RIA_REG_W-1:0]                    reg_wdata,
    output reg  [`RIA_REG_W-1:0]                    reg_rdata,
    output reg                                      reg_rvalid,
    output reg                                      reg_hit,
    input  wire [NPORT*`RIA_EXT_PHYS*`RIA_TADDR_W-1:0] ext_phys,
    input  wire [NPORT*`RIA_EXT_ALIAS*`RIA_REG_W-1:0]  ext_alias,
    input  wire                                     xact_valid,
    input  wire [PW-1:0]                            xact_port,
    input  wire [`RIA_TADDR_W-1:0]                  xact_addr,
    input  wire                                     xact_rnw,
    output reg                                      fwd_valid,
    output reg                                      fwd_hit,
    output reg  [PW-1:0]                            fwd_port,
    output reg  [`RIA_SLOT_W-1:0]                   fwd_slot,
    output reg  [`RIA_TADDR_W-1:0]                  fwd_addr,
    output reg                                      fwd_rnw,
    output reg                                      fwd_auto_ack
);

    localparam NREG = NPORT * `RIA_REGS_PER_PORT;

    // ==================================================================
    // register decode, shared by write and read paths
    function [`RIA_IDX_W-1:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `RIA_ADDR_PHYS3:  reg_index = 4'h0;
                `RIA_ADDR_PHYS4:  reg_index = 4'h1;
                `RIA_ADDR_PHYS5:  reg_index = 4'h2;
                `RIA_ADDR_PHYS6:  reg_index = 4'h3;
                `RIA_ADDR_PHYS7:  reg_index = 4'h4;
                `RIA_ADDR_ALIAS0: reg_index = 4'h5;
                `RIA_ADDR_ALIAS1: reg_index = 4'h6;
                default:          reg_index = `RIA_IDX_NONE;
            endcase
        end
    endfunction

    // ==================================================================
    // first storage index of a port's copy; the bus side and the
    // search side must agree on this layout, so both use it
    function integer port_base;
        input [PW-1:0] p;
        begin
            port_base = p * `RIA_REGS_PER_PORT;
        end
    endfunction

    reg  [`RIA_REG_W-1:0]       mem_reg [0:NREG-1];
    wire [`RIA_IDX_W-1:0]       acc_idx;
    wire                        acc_mapped;
    wire [31:0]                 acc_slot;
    wire [`RIA_REG_W-1:0]       wr_val;
    integer                     i;

    assign acc_idx    = reg_index(reg_addr);
    // unmapped offsets never touch storage
    assign acc_mapped = (acc_idx != `RIA_IDX_NONE);
    assign acc_slot   = port_base(port_sel) + acc_idx;
    // physical bit 0 held at zero
    assign wr_val   = (acc_idx < `RIA_IDX_ALIAS0) ?
                      (reg_wdata & `RIA_PHYS_MASK) : reg_wdata;

    // ==================================================================
    // register storage
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < NREG; i = i + 1)
                mem_reg[i] <= `RIA_RESET_VAL;
        end
        else if (reg_wr && acc_mapped)
        begin
            // alias read-write
            // a read in this same cycle still returns the old value
            mem_reg[acc_slot] <= wr_val;
        end
    end

    // ==================================================================
    // read path, one cycle; unmapped reads zero with reg_hit low
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= `RIA_RESET_VAL;
            reg_rvalid <= 1'b0;
            reg_hit    <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            // data and hit hold between reads for a slow master
            if (reg_rd)
            begin
                reg_hit <= acc_mapped;
                if (acc_mapped)
                    reg_rdata <= mem_reg[acc_slot];
                else
                    reg_rdata <= `RIA_RESET_VAL;
            end
        end
    end

    // ==================================================================
    // slot table of the addressed port
    // slots outside this block's map come from the neighbouring
    // register file, so the search still covers all eight slots
    // tables are read combinationally, so a register write in the
    // same cycle as a transaction is not yet seen by it
    reg  [`RIA_SLOTS*`RIA_REG_W-1:0]     alias_bus;
    reg  [`RIA_SLOTS*`RIA_TADDR_W-1:0]   phys_bus;
    reg  [`RIA_REG_W-1:0]                tmp;
    integer                              k;
    integer                              base;

    always @*
    begin
        alias_bus = {`RIA_SLOTS*`RIA_REG_W{1'b0}};
        phys_bus  = {`RIA_SLOTS*`RIA_TADDR_W{1'b0}};
        tmp       = `RIA_RESET_VAL;
        base      = port_base(xact_port);
        for (k = 0; k < `RIA_SLOTS; k = k + 1)
        begin
            if (k < `RIA_PHYS_FIRST)
                phys_bus[k*`RIA_TADDR_W +: `RIA_TADDR_W] =
                    ext_phys[(xact_port*`RIA_EXT_PHYS + k)*`RIA_TADDR_W
                             +: `RIA_TADDR_W];
            else
            begin
                tmp = mem_reg[base + k - `RIA_PHYS_FIRST];
                phys_bus[k*`RIA_TADDR_W +: `RIA_TADDR_W] =
                    tmp[`RIA_ADDR_MSB:`RIA_ADDR_LSB];
            end
            if (k < `RIA_ALIAS_LOCAL)
                alias_bus[k*`RIA_REG_W +: `RIA_REG_W] =
                    mem_reg[base + `RIA_IDX_ALIAS0 + k];
            else
                alias_bus[k*`RIA_REG_W +: `RIA_REG_W] =
                    ext_alias[(xact_port*`RIA_EXT_ALIAS + k
                               - `RIA_ALIAS_LOCAL)*`RIA_REG_W
                              +: `RIA_REG_W];
        end
    end

    wire                        m_hit;
    wire [`RIA_SLOT_W-1:0]      m_slot;
    wire [`RIA_TADDR_W-1:0]     m_phys;
    wire                        m_ack;

    ria_slot_match u_match
    (
        .addr_in   (xact_addr),
        .alias_bus (alias_bus),
        .phys_bus  (phys_bus),
        .hit       (m_hit),
        .slot      (m_slot),
        .phys_addr (m_phys),
        .auto_ack  (m_ack)
    );

    wire [`RIA_TADDR_W-1:0]     fwd_addr_next;
    wire                        fwd_ack_next;

    // remapped address on a hit; a miss passes the host address
    // through untouched and downstream decides
    assign fwd_addr_next = m_hit ? m_phys : xact_addr;
    // writes only; lock and remote ack not consulted
    assign fwd_ack_next  = m_hit & m_ack & ~xact_rnw;

    // ==================================================================
    // forward request toward the control channel
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd_valid    <= 1'b0;
            fwd_hit      <= 1'b0;
            fwd_port     <= {PW{1'b0}};
            fwd_slot     <= {`RIA_SLOT_W{1'b0}};
            fwd_addr     <= `RIA_NO_ALIAS;
            fwd_rnw      <= 1'b0;
            fwd_auto_ack <= 1'b0;
        end
        else
        begin
            fwd_valid <= xact_valid;
            if (xact_valid)
            begin
                fwd_hit  <= m_hit;
                fwd_port <= xact_port;
                fwd_slot <= m_slot;
                fwd_rnw  <= xact_rnw;
                fwd_addr     <= fwd_addr_next;
                // auto-ack flag registered with the request
                fwd_auto_ack <= fwd_ack_next;
            end
        end
    end

endmodule // ria_alias_remap

// [design/ria_slot_match.v]
`timescale 1ns/10ps
`include "ria_defines.vh"

module ria_slot_match
(
    input  wire [`RIA_TADDR_W-1:0]              addr_in,
    input  wire [`RIA_SLOTS*`RIA_REG_W-1:0]     alias_bus,
    input  wire [`RIA_SLOTS*`RIA_TADDR_W-1:0]   phys_bus,
    output reg                                  hit,
    output reg  [`RIA_SLOT_W-1:0]               slot,
    output reg  [`RIA_TADDR_W-1:0]              phys_addr,
    output reg                                  auto_ack
);

    integer                 k;
    reg [`RIA_REG_W-1:0]    entry;

    // ==================================================================
    // priority search
    always @*
    begin
        entry     = `RIA_RESET_VAL;
        hit       = 1'b0;
        slot      = {`RIA_SLOT_W{1'b0}};
        phys_addr = `RIA_NO_ALIAS;
        auto_ack  = 1'b0;
        for (k = `RIA_SLOTS - 1; k >= 0; k = k - 1)
        begin
            entry = alias_bus[k*`RIA_REG_W +: `RIA_REG_W];
            if (entry[`RIA_ADDR_MSB:`RIA_ADDR_LSB] != `RIA_NO_ALIAS &&
                entry[`RIA_ADDR_MSB:`RIA_ADDR_LSB] == addr_in)
            begin
                hit       = 1'b1;
                slot      = k[`RIA_SLOT_W-1:0];
                phys_addr = phys_bus[k*`RIA_TADDR_W +: `RIA_TADDR_W];
                auto_ack  = entry[`RIA_AUTO_ACK_BIT];
            end
        end
    end

endmodule // ria_slot_match

// [pkg/ria_defines.vh]
`ifndef RIA_DEFINES_VH
`define RIA_DEFINES_VH

// ======================================================================
// register offsets
`define RIA_ADDR_PHYS3      8'h60
`define RIA_ADDR_PHYS4      8'h61
`define RIA_ADDR_PHYS5      8'h62
`define RIA_ADDR_PHYS6      8'h63
`define RIA_ADDR_PHYS7      8'h64
`define RIA_ADDR_ALIAS0     8'h65
`define RIA_ADDR_ALIAS1     8'h66

// ======================================================================
// local register indices
`define RIA_IDX_W           4
`define RIA_IDX_PHYS3       4'h0
`define RIA_IDX_ALIAS0      4'h5
`define RIA_IDX_NONE        4'hf
`define RIA_REGS_PER_PORT   7
`define RIA_PHYS_FIRST      3
`define RIA_ALIAS_LOCAL     2
`define RIA_EXT_PHYS        3
`define RIA_EXT_ALIAS       6

// ======================================================================
// field layout and reset values
`define RIA_SLOTS           8
`define RIA_SLOT_W          3
`define RIA_ADDR_MSB        7
`define RIA_ADDR_LSB        1
`define RIA_AUTO_ACK_BIT    0
`define RIA_TADDR_W         7
`define RIA_REG_W           8
`define RIA_RESET_VAL       8'h00
`define RIA_PHYS_MASK       8'hfe
`define RIA_NO_ALIAS        7'h00

`endif

// [test/ria_alias_remap_checker.sv]
`timescale 1ns/10ps
module ria_alias_remap_checker
(
    input wire       core_clk,
    input wire       rst_n,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire       reg_rvalid,
    input wire       reg_hit,
    input wire       xact_valid,
    input wire [6:0] xact_addr,
    input wire       xact_rnw,
    input wire       fwd_valid,
    input wire       fwd_hit,
    input wire [6:0] fwd_addr,
    input wire       fwd_auto_ack
);
    // ====================
    // assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    a_phys_bit0: assert property (reg_rd && reg_addr <= 8'h64 &&
        reg_addr >= 8'h60 |=> !reg_rdata[0]) else $error("bit 0 set");
    a_unmapped_read: assert property (reg_rd && reg_addr > 8'h66 |=>
        !reg_hit && reg_rdata == 8'h00) else $error("unmapped read");
    a_fwd_answer: assert property (xact_valid |=> fwd_valid)
        else $error("no forward");
    a_miss_keeps: assert property (xact_valid ##1 !fwd_hit |->
        fwd_addr == $past(xact_addr)) else $error("miss altered addr");
    a_zero_never: assert property (xact_valid && xact_addr == 7'h00
        |=> !fwd_hit) else $error("zero alias matched");
    a_read_no_ack: assert property (xact_valid && xact_rnw
        |=> !fwd_auto_ack) else $error("read auto acked");
    a_ack_needs_hit: assert property (fwd_auto_ack |-> fwd_hit)
        else $error("auto ack on miss");
    cover property (fwd_valid && fwd_auto_ack);
    cover property (fwd_valid && !fwd_hit);
    cover property (reg_rvalid && reg_hit);
    cover property (reg_rvalid && !reg_hit);
endmodule // ria_alias_remap_checker

bind ria_alias_remap ria_alias_remap_checker u_chk (.core_clk(core_clk),
    .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .xact_valid(xact_valid), .xact_addr(xact_addr), .xact_rnw(xact_rnw),
    .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_addr(fwd_addr),
    .fwd_auto_ack(fwd_auto_ack));

// [test/ria_alias_remap_tb.sv]
`timescale 1ns/10ps
module ria_alias_remap_tb;
    // ====================
    // signals
    reg          core_clk, rst_n, reg_wr, reg_rd, xact_valid, xact_rnw;
    reg  [1:0]   port_sel, xact_port;
    reg  [7:0]   reg_addr, reg_wdata;
    reg  [6:0]   xact_addr;
    wire [7:0]   reg_rdata;
    wire         reg_rvalid, reg_hit, fwd_valid, fwd_hit, fwd_rnw;
    wire         fwd_auto_ack;
    wire [1:0]   fwd_port;
    wire [2:0]   fwd_slot;
    wire [6:0]   fwd_addr;
    wire [83:0]  ext_phys;
    wire [191:0] ext_alias;
    reg  [7:0]   shadow [0:27];
    logic [8:0]  rd_q[$];
    logic [14:0] tr_q[$];
    int          mismatches, check_count, i;

    ria_far_model u_far (.ext_phys(ext_phys), .ext_alias(ext_alias));
    ria_alias_remap uut (.core_clk(core_clk), .rst_n(rst_n),
        .port_sel(port_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .ext_phys(ext_phys),
        .ext_alias(ext_alias), .xact_valid(xact_valid),
        .xact_port(xact_port), .xact_addr(xact_addr), .xact_rnw(xact_rnw),
        .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_port(fwd_port),
        .fwd_slot(fwd_slot), .fwd_addr(fwd_addr), .fwd_rnw(fwd_rnw),
        .fwd_auto_ack(fwd_auto_ack));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ====================
    // tasks
    task conclude;
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task cmp_rd(input logic [8:0] got);
        logic [8:0] exp;
        exp = rd_q.size() ? rd_q.pop_front() : 'x;
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task cmp_fwd(input logic [14:0] got);
        logic [14:0] exp;
        exp = tr_q.size() ? tr_q.pop_front() : 'x;
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t fwd got %h exp %h", $time, got, exp);
        end
    endtask

    // one register access; reads note {hit, data}
    task acc(input w, input [1:0] p, input [7:0] a, d, input [8:0] e);
        @(negedge core_clk);
        port_sel = p;
        reg_addr = a;
        reg_wdata = d;
        if (w)
            reg_wr = 1'b1;
        else
        begin
            reg_rd = 1'b1;
            rd_q.push_back(e);
        end
        @(negedge core_clk);
        {reg_wr, reg_rd} = 2'b00;
    endtask

    // note is {hit, port, rnw, slot, addr, auto_ack}
    task tx(input [1:0] p, input [6:0] a, input r, input [14:0] e);
        @(negedge core_clk);
        {xact_port, xact_addr, xact_rnw, xact_valid} = {p, a, r, 1'b1};
        tr_q.push_back(e);
        @(negedge core_clk);
        xact_valid = 1'b0;
    endtask

    // ====================
    // monitor; slot is a don't-care on a miss
    always @(negedge core_clk)
    begin
        if (reg_rvalid === 1'b1)
            cmp_rd({reg_hit, reg_rdata});
        if (fwd_valid === 1'b1)
            cmp_fwd({fwd_hit, fwd_port, fwd_rnw, fwd_hit ? fwd_slot : 3'd0,
                fwd_addr, fwd_auto_ack});
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        $display("[FAIL] %0t run timed out", $time);
        conclude();
    end

    // ====================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, xact_valid, xact_rnw, port_sel, xact_port} = '0;
        {reg_addr, reg_wdata, xact_addr} = '0;
        void'($urandom(59));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++)
            acc(0, 0, 8'(8'h60 + i), 8'h00, {i < 7, 8'h00});
        acc(1, 0, 8'h67, 8'hff, 9'h000);
        for (i = 0; i < 28; i++)
        begin
            shadow[i] = 8'($urandom);
            acc(1, 2'(i / 7), 8'(8'h60 + i % 7), shadow[i], 9'h000);
        end
        for (i = 0; i < 28; i++)
            acc(0, 2'(i / 7), 8'(8'h60 + i % 7), 8'h00, {1'b1, (i % 7 < 5)
                ? (shadow[i] & 8'hfe) : shadow[i]});
        acc(0, 0, 8'h67, 8'h00, 9'h000);
        acc(1, 1, 8'h65, {7'h11, 1'b1}, 9'h000);
        acc(1, 1, 8'h66, {7'h11, 1'b0}, 9'h000);
        tx(1, 7'h11, 0, {1'b1, 2'd1, 1'b0, 3'd0, 7'h43, 1'b1});
        tx(1, 7'h11, 1, {1'b1, 2'd1, 1'b1, 3'd0, 7'h43, 1'b0});
        acc(1, 1, 8'h65, 8'h01, 9'h000);
        tx(1, 7'h11, 0, {1'b1, 2'd1, 1'b0, 3'd1, 7'h44, 1'b0});
        tx(1, 7'h00, 0, {1'b0, 2'd1, 1'b0, 3'd0, 7'h00, 1'b0});
        acc(1, 0, 8'h65, 8'h00, 9'h000);
        acc(1, 0, 8'h66, 8'h00, 9'h000);
        tx(0, 7'h33, 0, {1'b1, 2'd0, 1'b0, 3'd2, 7'h42, 1'b1});
        tx(0, 7'h34, 0, {4'b1000, 3'd3, shadow[0][7:1], 1'b0});
        tx(0, 7'h7f, 1, {4'b0001, 3'd0, 7'h7f, 1'b0});
        // last port: external slot tables indexed by the port number
        acc(1, 3, 8'h65, {7'h22, 1'b1}, 9'h000);
        tx(3, 7'h22, 0, {1'b1, 2'd3, 1'b0, 3'd0, 7'h49, 1'b1});
        // mid-run reset clears every copy
        repeat (2) @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        acc(0, 1, 8'h66, 8'h00, 9'h100);
        acc(0, 0, 8'h60, 8'h00, 9'h100);
        repeat (4) @(negedge core_clk);
        if (rd_q.size() != 0 || tr_q.size() != 0)
        begin
            mismatches++;
            $display("[FAIL] %0t results missing", $time);
        end
        conclude();
    end
endmodule // ria_alias_remap_tb

// [test/ria_far_model.sv]
`timescale 1ns/10ps
module ria_far_model
#(
    parameter NPORT = 4
)
(
    output logic [NPORT*21-1:0] ext_phys,
    output logic [NPORT*48-1:0] ext_alias
);
    // ====================
    // slot tables kept outside the block
    always_comb
    begin
        for (int k = 0; k < NPORT*3; k++)
            ext_phys[k*7 +: 7] = 7'(7'h40 + k);
        ext_alias = '0;
        // port 0 slot 2 auto-acks, slot 3 does not
        ext_alias[15:0] = {7'h34, 1'b0, 7'h33, 1'b1};
    end
endmodule // ria_far_model
